/* common/memory_init_pkg.sv */
// constants, command codes and address builders for the memory start-up sequencer
`default_nettype none
package memory_init_pkg;
    localparam int CLK_MHZ = 40;
    localparam int STAB_TIME_US = 200;
    // least time, exact at this rate
    localparam int STAB_CYC = STAB_TIME_US * CLK_MHZ;
    localparam int MRSC_CYC = 6;
    localparam int NOP_COUNT = 1024;
    localparam int BANKS = 8;
    localparam int DUMMY_LOADS = 2;
    localparam int ADDR_W = 19;
    localparam int BANK_W = 3;
    localparam int CFG_W = 10;
    localparam int TMR_W = 14;
    localparam int DUMMY_W = 4;
    localparam int NOPSEEN_W = 11;
    localparam int HIGH_LSB = 10;

    // mode field positions and the pins that carry them
    localparam int M_CFG0 = 0;
    localparam int M_CFG1 = 1;
    localparam int M_CFG2 = 2;
    localparam int M_BL0 = 3;
    localparam int M_BL1 = 4;
    localparam int M_AM = 5;
    localparam int M_NA = 6;
    localparam int M_DLL = 7;
    localparam int M_IM = 8;
    localparam int M_ODT = 9;

    // {chip select, write enable, refresh}, all active low
    typedef logic [2:0] cmd_t;
    localparam cmd_t CMD_NOP = 3'h7;
    localparam cmd_t CMD_MRL = 3'h0;
    localparam cmd_t CMD_BANK_AUTO_REFRESH = 3'h2;

    function automatic logic [ADDR_W-1:0] mrl_direct(input logic [CFG_W-1:0] cfg,
                                                     input logic am);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[CFG_W-1:0] = cfg;
        a[M_AM] = am;
        return a;
    endfunction : mrl_direct

    // first cycle of the two-cycle multiplexed load; the mux select A5 is high here and low in the second cycle
    function automatic logic [ADDR_W-1:0] mrl_ax(input logic [CFG_W-1:0] cfg);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[M_CFG0] = cfg[M_CFG0];
        a[M_BL0] = cfg[M_BL0];
        a[M_BL1] = cfg[M_BL1];
        a[M_AM] = 1'b1;
        a[M_IM] = cfg[M_IM];
        a[M_ODT] = cfg[M_ODT];
        return a;
    endfunction : mrl_ax

    function automatic logic [ADDR_W-1:0] mrl_ay(input logic [CFG_W-1:0] cfg);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[M_BL0] = cfg[M_CFG1];
        a[M_BL1] = cfg[M_CFG2];
        a[M_IM] = cfg[M_NA];
        a[M_ODT] = cfg[M_DLL];
        return a;
    endfunction : mrl_ay
endpackage : memory_init_pkg
`default_nettype wire

/* common/tmr_if.sv */
// load and expiry signals between the sequencer and its cycle counter
`timescale 1ns/1ps
`default_nettype none
interface tmr_if #(parameter int W = 14);
    logic load;
    logic [W-1:0] value;
    logic zero;
    modport ctl (output load, output value, input zero);
    modport cnt (input load, input value, output zero);
endinterface : tmr_if
`default_nettype wire

/* dv/mem_device_model.sv */
// behavioural memory device that watches the start-up command stream
`timescale 1ns/1ps
`default_nettype none
module mem_device_model
    import memory_init_pkg::*;
#(
    parameter int NOP_NEED = NOP_COUNT,
    parameter int ROW_CYC = 4
) (
    input wire logic ref_clk_i,            // command clock
    input wire logic [2:0] cmd_i,          // {cs, we, refresh}, active low
    input wire logic [ADDR_W-1:0] addr_i,  // address pins
    input wire logic [BANK_W-1:0] bank_i,  // bank pins
    output logic mux_o,                    // multiplexed address mode
    output logic ready_o,                  // normal use allowed
    output logic err_o                     // bank refreshed again too soon
);
    logic [BANKS-1:0] seen = '0;
    int nops = 0;
    int cyc = 0;
    int last [BANKS];
    initial begin
        mux_o = 1'b0;
        ready_o = 1'b0;
        err_o = 1'b0;
        foreach (last[b]) last[b] = -100;
    end
    // no-ops count from the last load, so refreshes may fall anywhere among them
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cmd_i == CMD_MRL) begin
            if (addr_i[M_AM]) mux_o <= 1'b1;
            seen <= '0;
            nops <= 0;
        end else if (cmd_i == CMD_BANK_AUTO_REFRESH) begin
            if (cyc - last[bank_i] < ROW_CYC) err_o <= 1'b1;
            last[bank_i] <= cyc;
            seen[bank_i] <= 1'b1;
        end else if (cmd_i == CMD_NOP) begin
            nops <= nops + 1;
        end
        if (&seen && nops >= NOP_NEED) ready_o <= 1'b1;
    end
endmodule : mem_device_model
`default_nettype wire

/* dv/memory_powerup_init_sequencer_tb.sv */
// self-checking bench for the memory start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module memory_powerup_init_sequencer_tb;
    import memory_init_pkg::*;
    localparam int STAB = 16;
    localparam int NOPS = 16;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic mux_mode_i = 1'b0;
    logic banks_idle_i = 1'b1;
    logic reinit_i = 1'b0;
    logic mux_req_i = 1'b0;
    logic [CFG_W-1:0] cfg_i = 10'h3A5;
    logic cs_n, we_n, ref_n, mux_sel, done, dev_mux, dev_ready, dev_err;
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] ay;
    int error_cnt = 0;
    int checks = 0;
    int done_cyc;
    int ev_cyc[$];
    cmd_t ev_cmd[$];
    logic [ADDR_W-1:0] ev_addr[$];
    logic [BANK_W-1:0] ev_bank[$];

    initial forever #12.5 ref_clk_i = ~ref_clk_i;

    memory_powerup_init_sequencer #(.STAB_CYCLES(STAB), .NOP_CYCLES(NOPS)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_i), .mux_mode_i(mux_mode_i),
        .cfg_i(cfg_i), .banks_idle_i(banks_idle_i), .reinit_i(reinit_i),
        .mux_req_i(mux_req_i), .chip_sel_n_o(cs_n), .write_en_n_o(we_n),
        .refresh_n_o(ref_n), .addr_o(addr), .bank_o(bank),
        .address_mux_select_o(mux_sel), .init_done_o(done));

    mem_device_model #(.NOP_NEED(NOPS)) dev (
        .ref_clk_i(ref_clk_i), .cmd_i({cs_n, we_n, ref_n}), .addr_i(addr),
        .bank_i(bank), .mux_o(dev_mux), .ready_o(dev_ready), .err_o(dev_err));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [ADDR_W-1:0] exp_valid(input logic am);
        logic [ADDR_W-1:0] a;
        a = {9'h000, cfg_i};
        a[5] = am;
        return a;
    endfunction : exp_valid

    function automatic logic [ADDR_W-1:0] exp_ax();
        return {9'h000, cfg_i[9], cfg_i[8], 2'h0, 1'b1, cfg_i[4], cfg_i[3], 2'h0, cfg_i[0]};
    endfunction : exp_ax

    function automatic logic [ADDR_W-1:0] exp_ay();
        return {9'h000, cfg_i[7], cfg_i[6], 3'h0, cfg_i[2], cfg_i[1], 3'h0};
    endfunction : exp_ay

    // logs every non-nop command until done rises again after having been low
    task automatic capture();
        bit was_low;
        bit prev_load;
        cmd_t c;
        was_low = 1'b0;
        prev_load = 1'b0;
        ev_cyc = {};
        ev_cmd = {};
        ev_addr = {};
        ev_bank = {};
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk_i);
            reinit_i <= 1'b0;
            mux_req_i <= 1'b0;
            #1;
            c = {cs_n, we_n, ref_n};
            if (prev_load) ay = addr;
            prev_load = (c === CMD_MRL);
            if (c !== CMD_NOP) begin
                ev_cyc.push_back(i);
                ev_cmd.push_back(c);
                ev_addr.push_back(addr);
                ev_bank.push_back(bank);
            end
            if (done !== 1'b1) begin
                was_low = 1'b1;
            end else if (was_low) begin
                done_cyc = i;
                return;
            end
        end
        chk("done timeout", 0, 1);
        tally_and_finish();
    endtask : capture

    task automatic check_run(input int dum, input bit vld, input bit ax, input bit refr,
                             input logic am, input int first_min);
        int k;
        logic [BANKS-1:0] mask;
        k = 0;
        mask = '0;
        chk("command count", ev_cyc.size(), dum + vld + ax + (refr ? BANKS : 0));
        if (ev_cyc.size() != dum + vld + ax + (refr ? BANKS : 0)) return;
        chk("stable wait", ev_cyc[0] >= first_min, 1);
        for (int d = 0; d < dum; d++) begin
            chk("dummy cmd", ev_cmd[k], CMD_MRL);
            chk("dummy addr", ev_addr[k], 0);
            if (k > 0) chk("dummy spacing", ev_cyc[k] - ev_cyc[k-1], 1);
            k++;
        end
        if (vld) begin
            chk("valid cmd", ev_cmd[k], CMD_MRL);
            chk("valid addr", ev_addr[k], exp_valid(am));
            if (dum > 0) chk("valid spacing", ev_cyc[k] - ev_cyc[k-1], 1);
            k++;
        end
        if (ax) begin
            chk("ax cmd", ev_cmd[k], CMD_MRL);
            chk("ax addr", ev_addr[k], exp_ax());
            chk("ay addr", ay, exp_ay());
            if (vld) chk("ax wait", ev_cyc[k] - ev_cyc[k-1] >= MRSC_CYC, 1);
            else chk("ax spacing", ev_cyc[k] - ev_cyc[k-1], 1);
            k++;
        end
        if (refr) begin
            chk("refresh wait", ev_cyc[k] - ev_cyc[k-1] >= MRSC_CYC + int'(ax), 1);
            for (int b = 0; b < BANKS; b++) begin
                chk("refresh cmd", ev_cmd[k+b], CMD_BANK_AUTO_REFRESH);
                mask[ev_bank[k+b]] = 1'b1;
            end
            k += BANKS;
            chk("banks refreshed", mask, 8'hFF);
            chk("nops before done", done_cyc - ev_cyc[k-1] >= NOPS, 1);
        end
        chk("mux select", mux_sel, am);
    endtask : check_run

    task automatic refused();
        @(posedge ref_clk_i);
        banks_idle_i <= 1'b0;
        reinit_i <= 1'b1;
        mux_req_i <= 1'b1;
        repeat (20) begin
            @(posedge ref_clk_i);
            #1;
            chk("busy banks done", done, 1);
            chk("busy banks cmd", {cs_n, we_n, ref_n}, CMD_NOP);
        end
        @(posedge ref_clk_i);
        reinit_i <= 1'b0;
        mux_req_i <= 1'b0;
        banks_idle_i <= 1'b1;
    endtask : refused

    task automatic startup_plain();
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        capture();
        check_run(2, 1, 0, 1, 1'b0, STAB);
        chk("device ready", dev_ready, 1);
    endtask : startup_plain

    // nothing may reach the pins at the edge that takes the request
    task automatic later_mux();
        @(posedge ref_clk_i);
        mux_req_i <= 1'b1;
        capture();
        check_run(0, 1, 1, 0, 1'b1, 1);
        chk("device mux", dev_mux, 1);
    endtask : later_mux

    task automatic replay_loads();
        @(posedge ref_clk_i);
        reinit_i <= 1'b1;
        capture();
        check_run(2, 0, 1, 1, 1'b1, 1);
    endtask : replay_loads

    // aborts a replay part way, then starts again in multiplexed mode
    task automatic reset_startup_mux();
        @(posedge ref_clk_i);
        reinit_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        reinit_i <= 1'b0;
        rst_i <= 1'b1;
        start_i <= 1'b0;
        mux_mode_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("reset cmd", {cs_n, we_n, ref_n}, CMD_NOP);
        chk("reset addr", addr, 0);
        chk("reset done", done, 0);
        chk("reset mux", mux_sel, 0);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        start_i <= 1'b1;
        capture();
        check_run(2, 1, 1, 1, 1'b1, STAB);
    endtask : reset_startup_mux

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk("ready before init", dev_ready, 0);
        startup_plain();
        refused();
        later_mux();
        replay_loads();
        reset_startup_mux();
        chk("bank reuse", dev_err, 0);
        tally_and_finish();
    end
endmodule : memory_powerup_init_sequencer_tb
`default_nettype wire

/* src/cycle_counter.sv */
// loadable down counter that flags when it has reached zero
`timescale 1ns/1ps
`default_nettype none
module cycle_counter #(
    parameter int W = 14
) (
    input wire logic ref_clk_i, // command clock
    input wire logic rst_i,     // async reset, high
    tmr_if.cnt tp               // load and expiry
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (tp.load) begin
            next_count = tp.value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tp.zero = (count == '0);
endmodule : cycle_counter
`default_nettype wire

/* src/memory_powerup_init_sequencer.sv */
// start-up sequencer that drives the memory command and address pins
//
// Overview of operation
// - nop commands continuously while starting up
// - stable nops for 200 us first
// - two dummy loads then one valid load
// - loads on consecutive cycles, nothing between
// - no recovery wait between start-up loads
// - dummy loads drive all address low
// - after recovery, refresh eight banks, 1024 nops
// - refreshes may interleave with the nops
// - row cycle time before reusing refreshed bank
// - A10 to A17 low during loads
// - A10 to A18 low in multiplexed mode
// - clock or supply change resets the dll
// - later load with A5 high also enters
// - recovery then two-cycle mux load, A5 high
// - recovery time after every valid load
// - loads only while all banks idle
`timescale 1ns/1ps
`default_nettype none
module memory_powerup_init_sequencer
    import memory_init_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_CYC,
    parameter int NOP_CYCLES = NOP_COUNT,
    parameter int DUMMIES = DUMMY_LOADS,
    parameter int TW = TMR_W
) (
    input wire logic ref_clk_i,              // command clock
    input wire logic rst_i,                  // async reset, high
    input wire logic start_i,                // supplies and clocks stable
    input wire logic mux_mode_i,             // wanted start-up address mode
    input wire logic [CFG_W-1:0] cfg_i,      // mode word M9..M0
    input wire logic banks_idle_i,           // no bank busy, no burst
    input wire logic reinit_i,               // clock period or supply changed
    input wire logic mux_req_i,              // switch to multiplexed mode later
    output logic chip_sel_n_o,               // memory chip select, low
    output logic write_en_n_o,               // memory write enable, low
    output logic refresh_n_o,                // memory refresh, low
    output logic [ADDR_W-1:0] addr_o,        // memory address pins
    output logic [BANK_W-1:0] bank_o,        // memory bank pins
    output logic address_mux_select_o,       // memory now in multiplexed mode
    output logic init_done_o                 // memory ready for normal use
);
    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_STAB = 4'h1,
        ST_DUMMY = 4'h2,
        ST_VALID = 4'h3,
        ST_MRSC = 4'h4,
        ST_MUXX = 4'h5,
        ST_MUXY = 4'h6,
        ST_REF = 4'h7,
        ST_NOPS = 4'h8,
        ST_DONE = 4'h9
    } state_e;

    state_e state, next_state;
    logic [DUMMY_W-1:0] dummy, next_dummy;
    logic [BANK_W-1:0] bank, next_bank;
    logic mux_want, next_mux_want;
    logic mux_pend, next_mux_pend;
    logic mux_on, next_mux_on;
    logic init_run, next_init_run;
    logic done, next_done;
    cmd_t cmd, next_cmd;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [BANK_W-1:0] bank_q, next_bank_q;

    tmr_if #(.W(TW)) tmr ();

    // one counter serves every wait, wide enough for the stabilisation time
    cycle_counter #(.W(TW)) u_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .tp (tmr.cnt)
    );

    always_comb begin
        next_state = state;
        next_dummy = dummy;
        next_bank = bank;
        next_mux_want = mux_want;
        next_mux_pend = mux_pend;
        next_mux_on = mux_on;
        next_init_run = init_run;
        next_done = done;
        next_cmd = CMD_NOP;
        next_addr = '0;
        next_bank_q = '0;
        tmr.load = 1'b0;
        tmr.value = '0;
        case (state)
            ST_OFF: begin
                if (start_i) begin
                    next_mux_want = mux_mode_i;
                    next_init_run = 1'b1;
                    tmr.load = 1'b1;
                    tmr.value = TW'(STAB_CYCLES - 1);
                    next_state = ST_STAB;
                end
            end
            ST_STAB: begin
                if (tmr.zero) begin
                    next_dummy = '0;
                    next_state = ST_DUMMY;
                end
            end
            ST_DUMMY: begin
                // all-low address also leaves the dll in reset
                next_cmd = CMD_MRL;
                next_dummy = dummy + 1'b1;
                if (dummy == DUMMY_W'(DUMMIES - 1)) begin
                    // valid load follows at once, recovery not needed
                    next_state = mux_on ? ST_MUXX : ST_VALID;
                end
            end
            ST_VALID: begin
                next_cmd = CMD_MRL;
                next_addr = mrl_direct(cfg_i, mux_want);
                next_mux_pend = mux_want;
                tmr.load = 1'b1;
                tmr.value = TW'(MRSC_CYC - 2);
                next_state = ST_MRSC;
            end
            ST_MRSC: begin
                if (tmr.zero) begin
                    if (mux_pend) begin
                        next_mux_pend = 1'b0;
                        next_state = ST_MUXX;
                    end else if (init_run) begin
                        next_bank = '0;
                        next_state = ST_REF;
                    end else begin
                        next_done = 1'b1;
                        next_state = ST_DONE;
                    end
                end
            end
            ST_MUXX: begin
                next_cmd = CMD_MRL;
                next_addr = mrl_ax(cfg_i);
                next_state = ST_MUXY;
            end
            ST_MUXY: begin
                next_addr = mrl_ay(cfg_i);
                next_mux_on = 1'b1;
                tmr.load = 1'b1;
                tmr.value = TW'(MRSC_CYC - 2);
                next_state = ST_MRSC;
            end
            ST_REF: begin
                // refreshes first, each bank once, then the nop run
                next_cmd = CMD_BANK_AUTO_REFRESH;
                next_bank_q = bank;
                next_bank = bank + 1'b1;
                if (bank == BANK_W'(BANKS - 1)) begin
                    tmr.load = 1'b1;
                    tmr.value = TW'(NOP_CYCLES - 1);
                    next_state = ST_NOPS;
                end
            end
            ST_NOPS: begin
                // the nop run far exceeds the row cycle time of every bank
                if (tmr.zero) begin
                    next_init_run = 1'b0;
                    next_done = 1'b1;
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (banks_idle_i) begin
                    if (reinit_i) begin
                        next_done = 1'b0;
                        next_init_run = 1'b1;
                        next_dummy = '0;
                        next_state = ST_DUMMY;
                    end else if (mux_req_i && !mux_on) begin
                        next_done = 1'b0;
                        next_mux_want = 1'b1;
                        next_state = ST_VALID;
                    end
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_OFF;
            dummy <= '0;
            bank <= '0;
            mux_want <= 1'b0;
            mux_pend <= 1'b0;
            mux_on <= 1'b0;
            init_run <= 1'b0;
            done <= 1'b0;
            cmd <= CMD_NOP;
            addr <= '0;
            bank_q <= '0;
        end else begin
            state <= next_state;
            dummy <= next_dummy;
            bank <= next_bank;
            mux_want <= next_mux_want;
            mux_pend <= next_mux_pend;
            mux_on <= next_mux_on;
            init_run <= next_init_run;
            done <= next_done;
            cmd <= next_cmd;
            addr <= next_addr;
            bank_q <= next_bank_q;
        end
    end

    assign chip_sel_n_o = cmd[2];
    assign write_en_n_o = cmd[1];
    assign refresh_n_o = cmd[0];
    assign addr_o = addr;
    assign bank_o = bank_q;
    assign address_mux_select_o = mux_on;
    assign init_done_o = done;

    // helper counts that only the checks below read
    logic [TW-1:0] stab_seen, next_stab_seen;
    logic [NOPSEEN_W:0] nop_seen, next_nop_seen;
    logic [DUMMY_W-1:0] ref_seen, next_ref_seen;
    always_comb begin
        next_stab_seen = (state == ST_STAB) ? stab_seen + 1'b1 : stab_seen;
        next_nop_seen = (state == ST_NOPS) ? nop_seen + 1'b1 : nop_seen;
        next_ref_seen = (state == ST_REF) ? ref_seen + 1'b1 : ref_seen;
        if (state == ST_DUMMY) begin
            next_nop_seen = '0;
            next_ref_seen = '0;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stab_seen <= '0;
            nop_seen <= '0;
            ref_seen <= '0;
        end else begin
            stab_seen <= next_stab_seen;
            nop_seen <= next_nop_seen;
            ref_seen <= next_ref_seen;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    stab_nop_a: assert property ((state == ST_STAB) |=> (cmd == CMD_NOP))
        else $error("command other than nop during stabilisation");
    stab_len_a: assert property (
        (state == ST_DUMMY && $past(state) == ST_STAB) |-> (stab_seen == TW'(STAB_CYCLES)))
        else $error("stabilisation wait has wrong length");
    dummy_addr_a: assert property (
        (state == ST_DUMMY) |=> (cmd == CMD_MRL && addr_o == '0))
        else $error("dummy load without all-low address");
    loads_back_a: assert property (
        (state == ST_DUMMY && dummy == '0) |=> (cmd == CMD_MRL) [*3])
        else $error("start-up loads not on consecutive cycles");
    high_addr_a: assert property (
        (cmd == CMD_MRL) |-> (addr_o[ADDR_W-1:HIGH_LSB] == '0))
        else $error("upper address bits high during a load");
    mrsc_gap_a: assert property (
        (state == ST_VALID) |=> (cmd == CMD_MRL) ##1 (cmd == CMD_NOP) [*5])
        else $error("command within recovery time of a load");
    bank_refresh_a: assert property (
        (state == ST_REF && bank == '0) |=> (cmd == CMD_BANK_AUTO_REFRESH && bank_o == '0) [*1]
            ##7 (cmd == CMD_BANK_AUTO_REFRESH && bank_o == BANK_W'(BANKS - 1)))
        else $error("eight bank refreshes not issued in order");
    done_after_a: assert property (
        $rose(init_done_o) |-> (nop_seen == (NOPSEEN_W+1)'(NOP_CYCLES)
            && ref_seen == DUMMY_W'(BANKS)))
        else $error("done raised before refreshes and nops were complete");
    mux_a5_a: assert property (
        (state == ST_MUXX) |=> (cmd == CMD_MRL && addr_o[M_AM]) ##1 (cmd == CMD_NOP))
        else $error("multiplexed load without mux select high");
    idle_gate_a: assert property (
        (state == ST_DONE && !banks_idle_i) |=> (state == ST_DONE && cmd == CMD_NOP))
        else $error("load started while banks busy");
endmodule : memory_powerup_init_sequencer
`default_nettype wire
